// >>> rtl/core_dm_consts.svh
`ifndef CORE_DM_CONSTS_SVH
`define CORE_DM_CONSTS_SVH

// Banked-page locations decoded inside this block.
`define LOC_INDIRECT      7'h00
`define LOC_TIMER0        7'h01
`define LOC_PC_LOW        7'h02
`define LOC_STATUS        7'h03
`define LOC_POINTER       7'h04
`define LOC_PC_HIGH_BUF   7'h0A
`define LOC_GPR_BASE      7'h20
`define LOC_GPR_SHARED    7'h40

// General register storage: bank 0 holds 0x20-0x7F, bank 1 holds 0x20-0x3F.
`define GPR_DEPTH         128
`define GPR_INDEX_W       7
`define GPR_BANK1_OFFSET  7'h40

// Status register bit positions.
`define ST_CARRY          0
`define ST_HALF_CARRY     1
`define ST_ZERO           2
`define ST_POWER_DOWN     3
`define ST_TIMEOUT        4
`define ST_SPARE          5
`define ST_BANK_LO        6
`define ST_BANK_HI        7

// Reset values.
`define STATUS_RST        8'h18
`define POINTER_RST       8'h00
`define PC_RST            11'h000
`define PC_HIGH_BUF_RST   3'h0
`define TIMER0_RST        8'h00
`define BYTE_ZERO         8'h00

// Field widths and steps.
`define PC_W              11
`define PC_STEP           11'h001
`define TIMER0_STEP       8'h01
`define AUX_ADDR_W        5
`define NIBBLE_TOP        3

`endif

// >>> rtl/core_dm_pkg.sv
package core_dm_pkg;

   // Which register page an access targets; the page is set by the instruction kind.
   typedef enum logic [2:0]
   {
      PAGE_BANKED = 3'b001,
      PAGE_FIRST  = 3'b010,
      PAGE_SECOND = 3'b100
   } page_t;

   // How the program counter moves at the end of an instruction.
   typedef enum logic [5:0]
   {
      PC_NEXT       = 6'b000001,
      PC_SHORT_JUMP = 6'b000010,
      PC_SHORT_CALL = 6'b000100,
      PC_LONG_JUMP  = 6'b001000,
      PC_LONG_CALL  = 6'b010000,
      PC_RETURN     = 6'b100000
   } pc_op_t;

   // Flag-producing operation of the current instruction.
   typedef enum logic [3:0]
   {
      ALU_NONE  = 4'b0001,
      ALU_ADD   = 4'b0010,
      ALU_SUB   = 4'b0100,
      ALU_LOGIC = 4'b1000
   } alu_op_t;

   // Timer0 count source, chosen by the mode register and the configuration word.
   typedef enum logic [2:0]
   {
      T0_INSTR_CLK = 3'b001,
      T0_EXT_PIN   = 3'b010,
      T0_LOW_OSC   = 3'b100
   } t0_src_t;

   // Data access from the instruction decoder.
   typedef struct packed
   {
      logic       valid;
      logic       write;
      page_t      page;
      logic [6:0] addr;
      logic [7:0] wdata;
   } acc_req_t;

   // Access forwarded to registers that live outside this block.
   typedef struct packed
   {
      logic       valid;
      logic       write;
      page_t      page;
      logic [6:0] addr;
      logic [7:0] wdata;
   } ext_req_t;

   // Program counter control for the finishing instruction.
   typedef struct packed
   {
      logic        done;
      pc_op_t      op;
      logic [10:0] target;
      logic [10:0] ret_addr;
   } pc_req_t;

   // Flag update request from the arithmetic unit.
   typedef struct packed
   {
      alu_op_t    op;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] result;
   } alu_req_t;

   // Return-stack push toward the stack.
   typedef struct packed
   {
      logic        valid;
      logic [10:0] addr;
   } push_t;

   // Whole state of the core register block.
   typedef struct packed
   {
      logic [10:0] pc;
      logic [2:0]  pc_high_buf;
      logic [7:0]  status;
      logic [7:0]  pointer;
      logic [7:0]  timer0;
      logic        ext_pin_prev;
      logic        low_osc_prev;
      logic [7:0]  rdata;
      logic        rvalid;
      push_t       push;
   } core_state_t;

endpackage

// >>> rtl/gpr_ram.sv
`timescale 1ns/1ps

module gpr_ram #(
   parameter int DEPTH  = 128,
   parameter int ADDR_W = 7,
   parameter int DATA_W = 8
)(
   // Clock.
   input  wire logic              core_clk,
   // Write port.
   input  wire logic              we,
   input  wire logic [ADDR_W-1:0] waddr,
   input  wire logic [DATA_W-1:0] wdata,
   // Combinational read port.
   input  wire logic [ADDR_W-1:0] raddr,
   output logic      [DATA_W-1:0] rdata
);

   logic [DATA_W-1:0] mem [DEPTH];

   // Plain SRAM: contents are undefined after power-up, so there is no reset.
   always_ff @(posedge core_clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   // Asynchronous read keeps a register-to-register access inside one cycle.
   assign rdata = mem[raddr];

endmodule

// >>> rtl/core_data_memory_addressing.sv
`timescale 1ns/1ps
`include "core_dm_consts.svh"

module core_data_memory_addressing
   import core_dm_pkg::*;
(
   // Clock and reset.
   input  wire logic                  core_clk,
   input  wire logic                  nrst,
   // Data access from the decoder, answer one cycle later.
   input  wire core_dm_pkg::acc_req_t acc_req,
   output logic      [7:0]            acc_rdata,
   output logic                       acc_rvalid,
   // Registers held by the peripherals outside this block.
   output core_dm_pkg::ext_req_t      ext_req,
   input  wire logic [7:0]            ext_rdata,
   // Program counter control.
   input  wire core_dm_pkg::pc_req_t  pc_req,
   output logic      [10:0]           pc,
   output core_dm_pkg::push_t         stack_push,
   // Flag sources.
   input  wire core_dm_pkg::alu_req_t alu_req,
   input  wire logic                  clrwdt_exec,
   input  wire logic                  sleep_exec,
   input  wire logic                  wdt_timeout,
   // Timer0 sources.
   input  wire core_dm_pkg::t0_src_t  timer0_src,
   input  wire logic                  timer0_ext_clock_pin,
   input  wire logic                  low_osc_tick,
   // Status view for the rest of the core.
   output logic      [7:0]            core_status
);
   import core_dm_pkg::*;

   logic [1:0]               rst_sync_reg;
   logic                     rst_n;
   core_state_t              state_reg;
   core_state_t              state_next;
   logic [6:0]               loc;
   logic [1:0]               bank;
   logic                     loc_sfr;
   logic                     pointer_loop;
   logic [`GPR_INDEX_W-1:0]  gpr_index;
   logic                     gpr_we;
   logic [7:0]               gpr_rdata;
   logic                     bank_hit;
   logic                     hit_timer0;
   logic                     hit_pc_low;
   logic                     hit_status;
   logic                     hit_pointer;
   logic                     hit_high_buf;
   logic                     hit_gpr;
   logic                     to_ext;
   logic [8:0]               sum9;
   logic [4:0]               sum5;
   logic                     timer0_tick;
   logic [10:0]              pc_inc;

   // Reset is applied at once and released through two flops so every flop leaves
   // reset on the same edge.
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_sync_reg <= 2'b00;
      end
      else
      begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_reg[1];

   // Effective location: the pointer stands in for location 0x0.
   assign bank = state_reg.status[`ST_BANK_HI:`ST_BANK_LO];
   always_comb
   begin
      if (acc_req.addr == `LOC_INDIRECT)
      begin
         loc = state_reg.pointer[6:0];
      end
      else
      begin
         loc = acc_req.addr;
      end
   end

   // A pointer aimed at 0x0 would address itself; such accesses read zero and
   // write nothing rather than recursing. The auxiliary pages own a real 0x0.
   assign pointer_loop = (acc_req.page == PAGE_BANKED) && (acc_req.addr == `LOC_INDIRECT)
                         && (loc == `LOC_INDIRECT);
   assign loc_sfr      = loc < `LOC_GPR_BASE;

   // Special registers 0x00-0x1F exist once, so the bank is never looked at below
   // 0x20; this is what keeps 0x1B and 0x1F identical in all banks.
   always_comb
   begin
      if (loc >= `LOC_GPR_SHARED)
         gpr_index = loc - `LOC_GPR_BASE;
      else if (bank[0])
         gpr_index = loc + `GPR_BANK1_OFFSET;
      else
         gpr_index = loc - `LOC_GPR_BASE;
   end

   // Decode of banked-page accesses; auxiliary pages never reach the banked
   // decode, and banked accesses never reach the auxiliary pages.
   assign bank_hit     = acc_req.valid && (acc_req.page == PAGE_BANKED) && !pointer_loop;
   assign hit_timer0   = bank_hit && (loc == `LOC_TIMER0);
   assign hit_pc_low   = bank_hit && (loc == `LOC_PC_LOW);
   assign hit_status   = bank_hit && (loc == `LOC_STATUS);
   assign hit_pointer  = bank_hit && (loc == `LOC_POINTER);
   assign hit_high_buf = bank_hit && (loc == `LOC_PC_HIGH_BUF);
   assign hit_gpr      = bank_hit && !loc_sfr;
   assign gpr_we       = hit_gpr && acc_req.write;

   // Everything else goes out: banked special registers the block does not own
   // (0x1B and 0x1F among them, bank ignored) and both auxiliary pages.
   always_comb
   begin
      to_ext        = 1'b0;
      ext_req       = '0;
      ext_req.page  = acc_req.page;
      ext_req.write = acc_req.write;
      ext_req.wdata = acc_req.wdata;
      unique case (acc_req.page)
         PAGE_BANKED:
         begin
            to_ext       = bank_hit && loc_sfr && !hit_timer0 && !hit_pc_low && !hit_status
                           && !hit_pointer && !hit_high_buf && (loc != `LOC_INDIRECT);
            ext_req.addr = loc;
         end
         PAGE_FIRST:
         begin
            to_ext       = acc_req.valid;
            ext_req.addr = {2'b00, acc_req.addr[`AUX_ADDR_W-1:0]};
         end
         PAGE_SECOND:
         begin
            to_ext       = acc_req.valid;
            ext_req.addr = {2'b00, acc_req.addr[`AUX_ADDR_W-1:0]};
         end
         default:
         begin
            to_ext       = 1'b0;
            ext_req.addr = acc_req.addr;
         end
      endcase
      ext_req.valid = to_ext;
   end

   // General register storage for bank 0 and bank 1.
   gpr_ram #(
      .DEPTH  (`GPR_DEPTH),
      .ADDR_W (`GPR_INDEX_W),
      .DATA_W (8)
   ) u_gpr (
      .core_clk (core_clk),
      .we       (gpr_we),
      .waddr    (gpr_index),
      .wdata    (acc_req.wdata),
      .raddr    (gpr_index),
      .rdata    (gpr_rdata)
   );

   // Edge detect on the already-synchronous slow sources.
   always_comb
   begin
      unique case (timer0_src)
         T0_INSTR_CLK: timer0_tick = 1'b1;
         T0_EXT_PIN:   timer0_tick = timer0_ext_clock_pin && !state_reg.ext_pin_prev;
         T0_LOW_OSC:   timer0_tick = low_osc_tick && !state_reg.low_osc_prev;
         default:      timer0_tick = 1'b0;
      endcase
   end

   assign sum9   = {1'b0, alu_req.a} + {1'b0, alu_req.b};
   assign sum5   = {1'b0, alu_req.a[`NIBBLE_TOP:0]} + {1'b0, alu_req.b[`NIBBLE_TOP:0]};
   assign pc_inc = state_reg.pc + `PC_STEP;

   // Next-state logic for every register of the block.
   always_comb
   begin
      state_next              = state_reg;
      state_next.ext_pin_prev = timer0_ext_clock_pin;
      state_next.low_osc_prev = low_osc_tick;
      state_next.push         = '0;
      state_next.rvalid       = acc_req.valid && !acc_req.write;

      // Timer0: a software write wins over a count in the same cycle.
      if (hit_timer0 && acc_req.write)
         state_next.timer0 = acc_req.wdata;
      else if (timer0_tick)
         state_next.timer0 = state_reg.timer0 + `TIMER0_STEP;

      // Pointer and high buffer are plain storage.
      if (hit_pointer && acc_req.write)
         state_next.pointer = acc_req.wdata;
      if (hit_high_buf && acc_req.write)
         state_next.pc_high_buf = acc_req.wdata[2:0];

      // Status write from software first; flag hardware then overrides its bits.
      if (hit_status && acc_req.write)
         state_next.status = acc_req.wdata;
      unique case (alu_req.op)
         ALU_ADD:
         begin
            state_next.status[`ST_CARRY]      = sum9[8];
            state_next.status[`ST_HALF_CARRY] = sum5[4];
            state_next.status[`ST_ZERO]       = (sum9[7:0] == `BYTE_ZERO);
         end
         ALU_SUB:
         begin
            state_next.status[`ST_CARRY]      = alu_req.a >= alu_req.b;
            state_next.status[`ST_HALF_CARRY] = alu_req.a[`NIBBLE_TOP:0]
                                                >= alu_req.b[`NIBBLE_TOP:0];
            state_next.status[`ST_ZERO]       = (alu_req.a == alu_req.b);
         end
         ALU_LOGIC:
         begin
            state_next.status[`ST_ZERO] = (alu_req.result == `BYTE_ZERO);
         end
         default:
         begin
            state_next.status = state_next.status;
         end
      endcase

      // Reset-cause flags: a set from the watchdog clear or sleep wins over a
      // timeout landing in the same cycle, so the clear event is never lost.
      if (sleep_exec)
         state_next.status[`ST_POWER_DOWN] = 1'b0;
      if (clrwdt_exec)
         state_next.status[`ST_POWER_DOWN] = 1'b1;
      if (wdt_timeout)
         state_next.status[`ST_TIMEOUT] = 1'b0;
      if (clrwdt_exec || sleep_exec)
         state_next.status[`ST_TIMEOUT] = 1'b1;

      // Program counter: a direct load beats a low-byte write, which beats the step.
      if (pc_req.done)
      begin
         unique case (pc_req.op)
            PC_SHORT_JUMP:
            begin
               state_next.pc = {state_reg.pc_high_buf[2:1], pc_req.target[8:0]};
            end
            PC_SHORT_CALL:
            begin
               state_next.pc = {state_reg.pc_high_buf, pc_req.target[7:0]};
               state_next.push.valid = 1'b1;
               state_next.push.addr  = pc_inc;
            end
            PC_LONG_JUMP:
            begin
               state_next.pc = pc_req.target;
            end
            PC_LONG_CALL:
            begin
               state_next.pc = pc_req.target;
               state_next.push.valid = 1'b1;
               state_next.push.addr  = pc_inc;
            end
            PC_RETURN:
            begin
               state_next.pc = pc_req.ret_addr;
            end
            PC_NEXT:
            begin
               if (hit_pc_low && acc_req.write)
               begin
                  state_next.pc = {state_reg.pc_high_buf, acc_req.wdata};
               end
               else
               begin
                  state_next.pc = pc_inc;
               end
            end
            default:
            begin
               state_next.pc = pc_inc;
            end
         endcase
      end
      else if (hit_pc_low && acc_req.write)
      begin
         state_next.pc = {state_reg.pc_high_buf, acc_req.wdata};
      end

      // Read data mux, captured into a flop; bits 10:8 of the counter have no read path.
      if (!acc_req.valid || acc_req.write || pointer_loop)
         state_next.rdata = `BYTE_ZERO;
      else if (to_ext)
         state_next.rdata = ext_rdata;
      else if (hit_timer0)
         state_next.rdata = state_reg.timer0;
      else if (hit_pc_low)
         state_next.rdata = state_reg.pc[7:0];
      else if (hit_status)
         state_next.rdata = state_reg.status;
      else if (hit_pointer)
         state_next.rdata = state_reg.pointer;
      else if (hit_high_buf)
         state_next.rdata = {5'b00000, state_reg.pc_high_buf};
      else if (hit_gpr)
         state_next.rdata = gpr_rdata;
      else
         state_next.rdata = `BYTE_ZERO;
   end

   // State register; timeout and power-down flags come out of reset set.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg              <= '0;
         state_reg.pc           <= `PC_RST;
         state_reg.pc_high_buf  <= `PC_HIGH_BUF_RST;
         state_reg.status       <= `STATUS_RST;
         state_reg.pointer      <= `POINTER_RST;
         state_reg.timer0       <= `TIMER0_RST;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state flops.
   assign acc_rdata   = state_reg.rdata;
   assign acc_rvalid  = state_reg.rvalid;
   assign pc          = state_reg.pc;
   assign stack_push  = state_reg.push;
   assign core_status = state_reg.status;

endmodule

// >>> tb/core_dm_monitor.sv
`timescale 1ns/1ps
// Port watcher for the register block; all properties idle while reset is held.
module core_dm_monitor
   import core_dm_pkg::*;
(
   // Clock and reset.
   input wire logic                  core_clk,
   input wire logic                  nrst,
   // Requests seen at the ports.
   input wire core_dm_pkg::acc_req_t acc_req,
   input wire core_dm_pkg::pc_req_t  pc_req,
   input wire core_dm_pkg::alu_req_t alu_req,
   input wire logic                  clrwdt_exec,
   input wire logic                  sleep_exec,
   input wire logic                  wdt_timeout,
   // Answers driven by the block.
   input wire core_dm_pkg::ext_req_t ext_req,
   input wire logic [10:0]           pc,
   input wire core_dm_pkg::push_t    stack_push,
   input wire logic [7:0]            core_status
);
   import core_dm_pkg::*;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   // Carry of the sum is kept as a signal so that it can be recalled a cycle later.
   logic [8:0] add_sum;
   logic       add_cy;
   assign add_sum = {1'b0, alu_req.a} + {1'b0, alu_req.b};
   assign add_cy  = add_sum[8];

   // Call steps: the request, then the pushed return address one cycle later.
   sequence long_call_s;
      pc_req.done && pc_req.op == PC_LONG_CALL;
   endsequence
   sequence short_call_s;
      pc_req.done && pc_req.op == PC_SHORT_CALL;
   endsequence
   sequence push_s;
      stack_push.valid && stack_push.addr == $past(pc) + 11'h001;
   endsequence

   ljump_load_a: assert property (
      pc_req.done && pc_req.op == PC_LONG_JUMP |=> pc == $past(pc_req.target))
      else $error("long jump target not loaded");
   long_call_a: assert property (
      long_call_s |=> push_s and pc == $past(pc_req.target))
      else $error("long call load or push wrong");
   sjump_low_a: assert property (
      pc_req.done && pc_req.op == PC_SHORT_JUMP |=> pc[8:0] == $past(pc_req.target[8:0]))
      else $error("short jump low bits wrong");
   short_call_a: assert property (
      short_call_s |=> push_s and pc[7:0] == $past(pc_req.target[7:0]))
      else $error("short call load or push wrong");
   pc_step_a: assert property (
      pc_req.done && pc_req.op == PC_NEXT && !(acc_req.valid && acc_req.write)
      |=> pc == $past(pc) + 11'h001)
      else $error("counter did not advance by one");
   sleep_flags_a: assert property (
      sleep_exec && !clrwdt_exec |=> core_status[4:3] == 2'b10)
      else $error("sleep flags wrong");
   clrwdt_flags_a: assert property (
      clrwdt_exec |=> core_status[4:3] == 2'b11)
      else $error("watchdog clear flags wrong");
   timeout_flag_a: assert property (
      wdt_timeout && !clrwdt_exec && !sleep_exec |=> !core_status[4])
      else $error("timeout flag not cleared");
   logic_zero_a: assert property (
      alu_req.op == ALU_LOGIC |=> core_status[2] == ($past(alu_req.result) == 8'h00))
      else $error("zero flag wrong");
   add_carry_a: assert property (
      alu_req.op == ALU_ADD |=> core_status[0] == $past(add_cy))
      else $error("carry flag wrong");
   aux_forward_a: assert property (
      acc_req.valid && acc_req.page == PAGE_FIRST
      |-> ext_req.valid && ext_req.page == PAGE_FIRST
          && ext_req.addr[4:0] == acc_req.addr[4:0])
      else $error("first page access not forwarded");
   shared_loc_a: assert property (
      acc_req.valid && acc_req.page == PAGE_BANKED && acc_req.addr == 7'h1B
      |-> ext_req.valid && ext_req.addr == 7'h1B)
      else $error("shared location not bank free");
endmodule

// >>> tb/core_data_memory_addressing_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench; every stimulus change is launched on a rising edge.
module core_data_memory_addressing_tb_top;
   import core_dm_pkg::*;
   logic        core_clk;
   logic        nrst;
   acc_req_t    acc_req;
   logic [7:0]  acc_rdata;
   logic        rvalid;
   logic [7:0]  ext_rdata;
   pc_req_t     pc_req;
   logic [10:0] pc;
   push_t       stack_push;
   alu_req_t    alu_req;
   logic [2:0]  events;
   t0_src_t     timer0_src;
   logic [1:0]  t0_in;
   logic [7:0]  core_status;
   logic [7:0]  rd;
   int          fails;
   int          check_count;

   // Design under test; events is {watchdog clear, sleep, timeout}.
   core_data_memory_addressing uut
   (
      .core_clk             (core_clk),
      .nrst                 (nrst),
      .acc_req              (acc_req),
      .acc_rdata            (acc_rdata),
      .acc_rvalid           (rvalid),
      .ext_req              (),
      .ext_rdata            (ext_rdata),
      .pc_req               (pc_req),
      .pc                   (pc),
      .stack_push           (stack_push),
      .alu_req              (alu_req),
      .clrwdt_exec          (events[2]),
      .sleep_exec           (events[1]),
      .wdt_timeout          (events[0]),
      .timer0_src           (timer0_src),
      .timer0_ext_clock_pin (t0_in[0]),
      .low_osc_tick         (t0_in[1]),
      .core_status          (core_status)
   );

   // Free-running 100 MHz clock.
   always #5 core_clk = ~core_clk;

   task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic finish_test;
      if (fails == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // One access; read data is registered, so it is taken just after the next edge.
   task automatic acc(input logic w, input page_t pg, input logic [6:0] a, input logic [7:0] d);
      @(posedge core_clk);
      acc_req <= {1'b1, w, pg, a, d};
      @(posedge core_clk);
      acc_req.valid <= 1'b0;
      #1 rd = acc_rdata;
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      acc(1'b1, PAGE_BANKED, a, d);
   endtask

   task automatic rdb(input logic [6:0] a);
      acc(1'b0, PAGE_BANKED, a, 8'h00);
   endtask

   // Status write keeps both reset-cause flags high and the arithmetic flags low.
   task automatic setbank(input logic [1:0] b);
      wr(7'h03, {b, 6'b011000});
   endtask

   // The return address mirrors the target, so a return lands on a known place.
   task automatic pco(input pc_op_t op, input logic [10:0] t);
      @(posedge core_clk);
      pc_req <= {1'b1, op, t, t};
      @(posedge core_clk);
      pc_req.done <= 1'b0;
      #1;
   endtask

   task automatic fl(input alu_op_t op, input logic [7:0] a, input logic [7:0] b,
                     input logic [7:0] r, input logic [2:0] e);
      @(posedge core_clk);
      alu_req <= {op, a, b, r};
      events <= e;
      @(posedge core_clk);
      alu_req.op <= ALU_NONE;
      events <= 3'b000;
      #1;
   endtask

   task automatic t_reset;
      chk("pc", 11'h000, pc);
      chk("status_top", 5'b00011, core_status[7:3]);
      rdb(7'h04);
      chk("pointer_top", 1'b0, rd[7]);
      chk("read_valid", 1'b1, rvalid);
   endtask

   task automatic t_banks;
      setbank(2'b00);
      wr(7'h20, 8'h11);
      wr(7'h40, 8'h44);
      setbank(2'b01);
      wr(7'h20, 8'h22);
      setbank(2'b10);
      rdb(7'h20);
      chk("bank2_low", 8'h11, rd);
      setbank(2'b11);
      rdb(7'h20);
      chk("bank3_low", 8'h22, rd);
      rdb(7'h40);
      chk("bank3_high", 8'h44, rd);
   endtask

   task automatic t_indirect;
      wr(7'h04, 8'hA5);
      wr(7'h00, 8'h77);
      setbank(2'b01);
      rdb(7'h25);
      chk("indirect_write", 8'h77, rd);
      rdb(7'h00);
      chk("indirect_read", 8'h77, rd);
      wr(7'h04, 8'h00);
      rdb(7'h00);
      chk("self_point", 8'h00, rd);
   endtask

   task automatic t_aux;
      setbank(2'b11);
      acc(1'b0, PAGE_FIRST, 7'h1F, 8'h00);
      chk("first_page", 8'h5A, rd);
      acc(1'b0, PAGE_SECOND, 7'h00, 8'h00);
      chk("second_page", 8'h5A, rd);
      rdb(7'h1B);
      chk("shared_loc", 8'h5A, rd);
   endtask

   // Unselected source sees one rising edge fewer, so any leak shows in the count.
   task automatic t_timer;
      wr(7'h01, 8'h80);
      rdb(7'h01);
      chk("timer_live", 8'h81, rd);
      for (int s = 0; s < 2; s++)
      begin
         @(posedge core_clk);
         timer0_src <= s ? T0_LOW_OSC : T0_EXT_PIN;
         wr(7'h01, 8'h10);
         for (int i = 0; i < 3; i++)
         begin
            @(posedge core_clk);
            t0_in <= (i == 0) ? (s ? 2'b10 : 2'b01) : 2'b11;
            @(posedge core_clk);
            t0_in <= 2'b00;
         end
         rdb(7'h01);
         chk("timer_source", 8'h13, rd);
      end
   endtask

   task automatic t_pc;
      wr(7'h0A, 8'h05);
      pco(PC_SHORT_JUMP, 11'h0C3);
      chk("short_jump", 11'h4C3, pc);
      pco(PC_SHORT_CALL, 11'h77E);
      chk("short_call", 11'h57E, pc);
      chk("short_push", 12'hCC4, stack_push);
      pco(PC_LONG_JUMP, 11'h7FF);
      chk("long_jump", 11'h7FF, pc);
      pco(PC_LONG_CALL, 11'h345);
      chk("long_push", 12'h800, stack_push);
      pco(PC_NEXT, 11'h000);
      chk("step", 11'h346, pc);
      wr(7'h02, 8'h9A);
      chk("low_write", 11'h59A, pc);
      rdb(7'h02);
      chk("low_read", 8'h9A, rd);
      pco(PC_RETURN, 11'h4C4);
      chk("return", 11'h4C4, pc);
   endtask

   task automatic t_flags;
      fl(ALU_ADD, 8'h0F, 8'h01, 8'h10, 3'b000);
      chk("add_half", 3'b010, core_status[2:0]);
      fl(ALU_ADD, 8'hF0, 8'h10, 8'h00, 3'b000);
      chk("add_carry", 3'b101, core_status[2:0]);
      fl(ALU_SUB, 8'h05, 8'h05, 8'h00, 3'b000);
      chk("sub_equal", 3'b111, core_status[2:0]);
      fl(ALU_SUB, 8'h03, 8'h04, 8'hFF, 3'b000);
      chk("sub_borrow", 3'b000, core_status[2:0]);
      fl(ALU_LOGIC, 8'h00, 8'h00, 8'h00, 3'b000);
      chk("logic_zero", 1'b1, core_status[2]);
      fl(ALU_NONE, 8'h00, 8'h00, 8'h00, 3'b010);
      chk("sleep", 2'b10, core_status[4:3]);
      fl(ALU_NONE, 8'h00, 8'h00, 8'h00, 3'b001);
      chk("timeout", 2'b00, core_status[4:3]);
      fl(ALU_NONE, 8'h00, 8'h00, 8'h00, 3'b100);
      chk("clrwdt", 2'b11, core_status[4:3]);
   endtask

   // Main sequence: reset through 8 cycles, then the scenarios.
   initial
   begin
      core_clk = 1'b0;
      nrst = 1'b0;
      acc_req = '0;
      ext_rdata = 8'h5A;
      pc_req = '0;
      alu_req = {ALU_NONE, 24'h000000};
      events = 3'b000;
      timer0_src = T0_INSTR_CLK;
      t0_in = 2'b00;
      fails = 0;
      check_count = 0;
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_reset;
      t_banks;
      t_indirect;
      t_aux;
      t_timer;
      t_pc;
      t_flags;
      finish_test;
   end

   // Watchdog well past the roughly 120 cycles the scenarios need.
   initial
   begin
      repeat (3000) @(posedge core_clk);
      fails++;
      finish_test;
   end
endmodule

bind core_data_memory_addressing core_dm_monitor mon
(
   .core_clk    (core_clk),
   .nrst        (nrst),
   .acc_req     (acc_req),
   .pc_req      (pc_req),
   .alu_req     (alu_req),
   .clrwdt_exec (clrwdt_exec),
   .sleep_exec  (sleep_exec),
   .wdt_timeout (wdt_timeout),
   .ext_req     (ext_req),
   .pc          (pc),
   .stack_push  (stack_push),
   .core_status (core_status)
);
